//--- logic/dhds_channel.sv
// digital pll channel: holdover control and dco steering
`include "dhds_consts.svh"
module dhds_channel (
    input  wire logic                    i_clk,
    input  wire logic                    i_reset_n,
    input  wire dhds_pkg::dhds_ctrl_t    i_ctrl,
    input  wire logic                    i_reference_loss,
    input  wire logic                    i_valid_ref_avail,
    input  wire logic                    i_freq_in_tol,
    input  wire logic                    i_phase_in_tol,
    input  wire logic [`DHDS_NUM_W-1:0]  i_loop_word,
    input  wire logic [`DHDS_NUM_W-1:0]  i_holdover_offset_word,
    input  wire logic                    i_offset_wr,
    input  wire logic [`DHDS_NUM_W-1:0]  i_feedback_numerator,
    input  wire logic                    i_fb_num_wr,
    input  wire logic [`DHDS_NUM_W-1:0]  i_analog_base_numerator,
    input  wire logic [`DHDS_DEV_W-1:0]  i_step_deviation_word,
    input  wire logic                    i_step_update_wr,
    input  wire logic                    i_step_update_bit,
    input  wire logic [`DHDS_SEL_W-1:0]  i_step_trigger_pin_sel,
    input  wire logic [`DHDS_SEL_W-1:0]  i_step_direction_pin_sel,
    input  wire logic                    i_pin_ctrl_en,
    input  wire logic [`DHDS_GPIO_N-1:0] i_gpio,
    input  wire logic [`DHDS_NUM_W-1:0]  i_ramp_step_size,
    input  wire logic [`DHDS_CNT_W-1:0]  i_ramp_step_period,
    output dhds_pkg::dhds_state_t        o_state,
    output dhds_pkg::dhds_lock_t         o_lock_status,
    output dhds_pkg::dhds_lock_t         o_status_pins,
    output logic                         o_history_valid,
    output logic [`DHDS_NUM_W-1:0]       o_fcw,
    output logic [`DHDS_NUM_W-1:0]       o_effective_analog_numerator,
    output logic                         o_ramp_done
);
    import dhds_pkg::*;

    dhds_state_t                 state_r;
    dhds_state_t                 state_nxt;
    logic [`DHDS_NUM_W-1:0]      fb_base_r;
    logic [`DHDS_NUM_W-1:0]      dco_off_r;
    logic [`DHDS_NUM_W-1:0]      hist_avg_r;
    logic [`DHDS_HIST_CNT_W-1:0] hist_cnt_r;
    logic [`DHDS_NUM_W-1:0]      fed_r;
    logic [`DHDS_CNT_W-1:0]      ramp_cnt_r;
    logic                        pin_step;
    logic                        pin_dir;
    logic                        step_go;
    logic                        step_down;
    logic                        hold_like;

    // =====================================
    // helpers
    function automatic logic [`DHDS_NUM_W-1:0] sgn_add(
        input logic [`DHDS_NUM_W-1:0] a,
        input logic [`DHDS_NUM_W-1:0] b);
        sgn_add = a + b; // two's complement wraps
    endfunction

    function automatic logic [`DHDS_NUM_W-1:0] dev_ext(
        input logic [`DHDS_DEV_W-1:0] d);
        dev_ext = {{(`DHDS_NUM_W-`DHDS_DEV_W){1'b0}}, d};
    endfunction

    dhds_gpio_step u_gpio (
        .i_clk      (i_clk),
        .i_reset_n  (i_reset_n),
        .i_gpio     (i_gpio),
        .i_trig_sel (i_step_trigger_pin_sel),
        .i_dir_sel  (i_step_direction_pin_sel),
        .o_step     (pin_step),
        .o_dir      (pin_dir)
    );

    // =====================================
    // operating state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            DHDS_FREE_RUN: begin
                if (i_valid_ref_avail) begin
                    state_nxt = DHDS_ACQUIRE;
                end
            end
            DHDS_ACQUIRE: begin
                if (!i_valid_ref_avail) begin
                    state_nxt = DHDS_FREE_RUN;
                end else if (i_freq_in_tol && i_phase_in_tol) begin
                    state_nxt = DHDS_LOCKED;
                end
            end
            DHDS_LOCKED: begin
                if (i_reference_loss && !i_valid_ref_avail) begin
                    // no averaged word yet means free-run
                    state_nxt = o_history_valid ? DHDS_HOLDOVER
                                                : DHDS_FREE_RUN;
                end
            end
            DHDS_HOLDOVER: begin
                if (i_valid_ref_avail) begin
                    state_nxt = DHDS_ACQUIRE;
                end
            end
            default: state_nxt = DHDS_FREE_RUN;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r <= DHDS_FREE_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // =====================================
    // lock flags: phase flag forced set, frequency flag frozen through holdover
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_lock_status <= '{1'b1, 1'b1};
            o_status_pins <= '{1'b1, 1'b1};
        end else begin
            if (state_nxt == DHDS_HOLDOVER) begin
                o_lock_status.phase_lock_loss_flag <= 1'b1;
                o_status_pins.phase_lock_loss_flag <= 1'b1;
            end else begin
                o_lock_status.phase_lock_loss_flag <= !i_phase_in_tol;
                o_status_pins.phase_lock_loss_flag <= !i_phase_in_tol;
            end
            if (state_nxt != DHDS_HOLDOVER) begin
                o_lock_status.freq_lock_loss_flag <= !i_freq_in_tol;
                o_status_pins.freq_lock_loss_flag <= !i_freq_in_tol;
            end
        end
    end

    // =====================================
    // tuning word history: running average after frequency lock
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hist_avg_r      <= `DHDS_NUM_ZERO;
            hist_cnt_r      <= '0;
            o_history_valid <= 1'b0;
        end else if (!i_ctrl.history_enable) begin
            hist_cnt_r      <= '0;
            o_history_valid <= 1'b0;
        end else if (state_r == DHDS_LOCKED &&
                     !o_lock_status.freq_lock_loss_flag) begin
            // exponential average; fixed shift keeps it adder-only
            hist_avg_r <= sgn_add(hist_avg_r,
                (($signed(i_loop_word) - $signed(hist_avg_r))
                 >>> `DHDS_HIST_SH));
            if (hist_cnt_r != `DHDS_HIST_FULL) begin
                hist_cnt_r <= hist_cnt_r + 1'b1;
            end else begin
                o_history_valid <= 1'b1;
            end
        end
    end

    // =====================================
    // dco steering of the feedback numerator
    assign step_go   = i_step_update_wr || (i_pin_ctrl_en && pin_step);
    assign step_down = i_step_update_wr ? i_step_update_bit : pin_dir;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fb_base_r <= `DHDS_NUM_ZERO;
            dco_off_r <= `DHDS_NUM_ZERO;
        end else begin
            if (i_fb_num_wr) begin
                fb_base_r <= i_feedback_numerator;
                dco_off_r <= `DHDS_NUM_ZERO;
            end else if (!i_ctrl.steering_enable) begin
                dco_off_r <= `DHDS_NUM_ZERO;
            end else if (step_go && state_r == DHDS_LOCKED) begin
                dco_off_r <= step_down
                    ? dco_off_r - dev_ext(i_step_deviation_word)
                    : sgn_add(dco_off_r,
                              dev_ext(i_step_deviation_word));
            end
        end
    end

    // =====================================
    // frequency word: loop path or holdover word
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_fcw <= `DHDS_NUM_ZERO;
        end else if (state_r == DHDS_HOLDOVER) begin
            o_fcw <= (i_ctrl.history_enable && o_history_valid)
                ? hist_avg_r
                : sgn_add(fb_base_r, i_holdover_offset_word);
        end else begin
            o_fcw <= sgn_add(fb_base_r, dco_off_r);
        end
    end

    // =====================================
    // analog numerator steering
    assign hold_like = (state_r != DHDS_LOCKED) ||
                       !i_ctrl.digital_loop_enable;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fed_r       <= `DHDS_NUM_ZERO;
            ramp_cnt_r  <= `DHDS_CNT_ZERO;
            o_ramp_done <= 1'b0;
        end else if (!i_ctrl.history_enable) begin
            fed_r       <= i_holdover_offset_word;
            ramp_cnt_r  <= `DHDS_CNT_ZERO;
            o_ramp_done <= 1'b1;
        end else if (i_offset_wr) begin
            // restart from what is fed so far
            ramp_cnt_r  <= `DHDS_CNT_ZERO;
            o_ramp_done <= 1'b0;
        end else if (fed_r != i_holdover_offset_word) begin
            if (ramp_cnt_r + `DHDS_CNT_ONE >= i_ramp_step_period) begin
                ramp_cnt_r <= `DHDS_CNT_ZERO;
                if ($signed(i_holdover_offset_word - fed_r) >
                        $signed(i_ramp_step_size)) begin
                    fed_r <= sgn_add(fed_r, i_ramp_step_size);
                end else if ($signed(fed_r - i_holdover_offset_word) >
                        $signed(i_ramp_step_size)) begin
                    fed_r <= fed_r - i_ramp_step_size;
                end else begin
                    fed_r <= i_holdover_offset_word;
                end
            end else begin
                ramp_cnt_r <= ramp_cnt_r + `DHDS_CNT_ONE;
            end
        end else begin
            o_ramp_done <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_effective_analog_numerator <= `DHDS_NUM_ZERO;
        end else if (hold_like && i_ctrl.loop_enable) begin
            o_effective_analog_numerator <=
                sgn_add(i_analog_base_numerator, fed_r);
        end else begin
            o_effective_analog_numerator <= i_analog_base_numerator;
        end
    end

    assign o_state = state_r;

    // =====================================
    // checks
    holdover_pll_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state_r == DHDS_HOLDOVER |-> o_lock_status.phase_lock_loss_flag)
        else $error("phase lock loss not set in holdover");
    holdover_flf_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state_r == DHDS_HOLDOVER && $past(state_r) == DHDS_HOLDOVER) |->
        $stable(o_lock_status.freq_lock_loss_flag))
        else $error("frequency flag moved in holdover");
    enter_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state_r == DHDS_LOCKED && i_reference_loss && !i_valid_ref_avail &&
         o_history_valid) |=> state_r == DHDS_HOLDOVER)
        else $error("holdover not entered");
    free_run_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state_r == DHDS_LOCKED && i_reference_loss && !i_valid_ref_avail &&
         !o_history_valid) |=> state_r == DHDS_FREE_RUN)
        else $error("free-run not entered");
    exit_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state_r == DHDS_HOLDOVER && i_valid_ref_avail) |=>
        state_r == DHDS_ACQUIRE)
        else $error("holdover not left");
    steer_clear_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (!i_ctrl.steering_enable && state_r == DHDS_LOCKED) ##1
        (state_r == DHDS_LOCKED && !i_fb_num_wr) |=> o_fcw == fb_base_r)
        else $error("offset not cleared");
    step_up_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_step_update_wr && !i_step_update_bit && !i_fb_num_wr &&
         i_ctrl.steering_enable && state_r == DHDS_LOCKED) |=>
        dco_off_r == $past(dco_off_r) + dev_ext($past(i_step_deviation_word)))
        else $error("step up wrong");
    abs_num_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_fb_num_wr && state_nxt == DHDS_LOCKED && state_r == DHDS_LOCKED)
        |=> ##1 o_fcw == $past(i_feedback_numerator, 2))
        else $error("absolute numerator not applied");
    ramp_done_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_ramp_done && i_ctrl.history_enable && !$past(i_offset_wr) |->
        fed_r == i_holdover_offset_word || $changed(i_holdover_offset_word))
        else $error("done before fully fed");
endmodule

//--- inc/dhds_consts.svh
// constants of the dpll holdover and dco steering channel
// Functional notes
// - enter holdover on loss, no valid input
// - no history: holdover uses signed offset word
// - history invalid uses offset; valid uses average
// - average history only after frequency lock, enabled
// - phase lock loss set on holdover entry
// - freeze frequency lock flag during holdover
// - valid input leaves holdover, reacquires lock
// - lock loss flags on status bits and pins
// - loop steers feedback; holdover steers analog numerator
// - 38-bit step added or subtracted per update
// - register step: 0 raises, 1 lowers
// - trigger pin edge steps; direction pin sets sign
// - steering disable restores original feedback numerator
// - numerator write sets frequency word directly
// - analog numerator equals base plus offset word
// - history mode feeds offset gradually by step, period
// - new offset word drops remaining steps
// - completion flag when offset fully fed
// - offset word is signed 40-bit
// - loss before valid history gives free-run
`ifndef DHDS_CONSTS_SVH
`define DHDS_CONSTS_SVH
`define DHDS_NUM_W      40
`define DHDS_DEV_W      38
`define DHDS_SEL_W      3
`define DHDS_GPIO_N     8
`define DHDS_HIST_SH    4
`define DHDS_HIST_CNT_W 5
`define DHDS_HIST_FULL  5'h10
`define DHDS_NUM_ZERO   40'h00_0000_0000
`define DHDS_CNT_W      16
`define DHDS_CNT_ZERO   16'h0000
`define DHDS_CNT_ONE    16'h0001
`endif

//--- inc/dhds_pkg.sv
// types of the dpll holdover and dco steering channel
`include "dhds_consts.svh"
package dhds_pkg;
    typedef enum logic [3:0] {
        DHDS_FREE_RUN = 4'h1,
        DHDS_ACQUIRE  = 4'h2,
        DHDS_LOCKED   = 4'h4,
        DHDS_HOLDOVER = 4'h8
    } dhds_state_t;

    typedef struct packed {
        logic freq_lock_loss_flag;
        logic phase_lock_loss_flag;
    } dhds_lock_t;

    typedef struct packed {
        logic                    loop_enable;
        logic                    digital_loop_enable;
        logic                    denominator_mode;
        logic                    history_enable;
        logic                    steering_enable;
    } dhds_ctrl_t;
endpackage

//--- logic/dhds_gpio_step.sv
// gpio step trigger and direction synchroniser
`include "dhds_consts.svh"
module dhds_gpio_step (
    input  wire logic                      i_clk,
    input  wire logic                      i_reset_n,
    input  wire logic [`DHDS_GPIO_N-1:0]   i_gpio,
    input  wire logic [`DHDS_SEL_W-1:0]    i_trig_sel,
    input  wire logic [`DHDS_SEL_W-1:0]    i_dir_sel,
    output logic                           o_step,
    output logic                           o_dir
);
    logic [`DHDS_GPIO_N-1:0] s1_r;
    logic [`DHDS_GPIO_N-1:0] s2_r;
    logic [`DHDS_GPIO_N-1:0] s3_r;
    logic                    trig_r;

    // =====================================
    // three stage synchroniser
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= i_gpio;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // =====================================
    // trigger level accepted when stages two and three agree
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            trig_r <= 1'b0;
            o_step <= 1'b0;
            o_dir  <= 1'b0;
        end else begin
            if (s2_r[i_trig_sel] == s3_r[i_trig_sel]) begin
                trig_r <= s3_r[i_trig_sel];
            end
            o_step <= (s2_r[i_trig_sel] == s3_r[i_trig_sel]) &&
                      s3_r[i_trig_sel] && !trig_r;
            if (s2_r[i_dir_sel] == s3_r[i_dir_sel]) begin
                o_dir <= s3_r[i_dir_sel];
            end
        end
    end
endmodule

//--- tb/dhds_host_model.sv
// host model driving the gpio step trigger and direction pins
`include "dhds_consts.svh"
module dhds_host_model (
    input  wire logic                    i_clk,
    input  wire logic [`DHDS_SEL_W-1:0]  i_trig_sel,
    input  wire logic [`DHDS_SEL_W-1:0]  i_dir_sel,
    output logic      [`DHDS_GPIO_N-1:0] o_gpio
);
    timeunit 1ns;
    timeprecision 1ns;
    logic                    trig  = 1'b0;
    logic                    dir   = 1'b0;
    logic [`DHDS_GPIO_N-1:0] noise = 8'h5a;
    // =============================================
    // pin levels
    // unused pins keep moving so a wrong pin select gets noticed
    always @(negedge i_clk) begin
        noise <= noise + 8'h01;
    end
    always_comb begin
        o_gpio = noise;
        o_gpio[i_dir_sel] = dir;
        o_gpio[i_trig_sel] = trig;
    end
    // =============================================
    // one step: direction settles before the trigger rises
    task automatic pulse(input logic down);
        dir = down;
        repeat (2) @(negedge i_clk);
        trig = 1'b1;
        repeat (6) @(negedge i_clk);
        trig = 1'b0;
        repeat (6) @(negedge i_clk);
    endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the dpll holdover and dco steering channel
`include "dhds_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import dhds_pkg::*;
    localparam int NW = `DHDS_NUM_W;
    // =============================================
    // signals
    logic                   i_clk, i_reset_n, i_reference_loss;
    logic                   i_valid_ref_avail, i_freq_in_tol;
    logic                   i_phase_in_tol, i_offset_wr, i_fb_num_wr;
    logic                   i_step_update_wr, i_step_update_bit;
    logic                   i_pin_ctrl_en, o_history_valid, o_ramp_done;
    dhds_ctrl_t             i_ctrl;
    logic [NW-1:0]          i_loop_word, i_holdover_offset_word;
    logic [NW-1:0]          i_feedback_numerator, i_analog_base_numerator;
    logic [NW-1:0]          i_ramp_step_size, o_fcw;
    logic [NW-1:0]          o_effective_analog_numerator, exp, o2;
    logic [`DHDS_DEV_W-1:0] i_step_deviation_word;
    logic [`DHDS_CNT_W-1:0] i_ramp_step_period;
    logic [`DHDS_SEL_W-1:0] i_step_trigger_pin_sel;
    logic [`DHDS_SEL_W-1:0] i_step_direction_pin_sel;
    logic [`DHDS_GPIO_N-1:0] i_gpio;
    dhds_state_t            o_state;
    dhds_lock_t             o_lock_status, o_status_pins;
    int                     mismatches, tests_run;
    logic                   d;

    dhds_channel DUT (
        .i_clk, .i_reset_n, .i_ctrl, .i_reference_loss,
        .i_valid_ref_avail, .i_freq_in_tol, .i_phase_in_tol,
        .i_loop_word, .i_holdover_offset_word, .i_offset_wr,
        .i_feedback_numerator, .i_fb_num_wr, .i_analog_base_numerator,
        .i_step_deviation_word, .i_step_update_wr, .i_step_update_bit,
        .i_step_trigger_pin_sel, .i_step_direction_pin_sel,
        .i_pin_ctrl_en, .i_gpio, .i_ramp_step_size, .i_ramp_step_period,
        .o_state, .o_lock_status, .o_status_pins, .o_history_valid,
        .o_fcw, .o_effective_analog_numerator, .o_ramp_done
    );
    dhds_host_model host (
        .i_clk, .i_trig_sel(i_step_trigger_pin_sel),
        .i_dir_sel(i_step_direction_pin_sel), .o_gpio(i_gpio)
    );
    // =============================================
    // helpers
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic check(input logic [NW-1:0] got, input logic [NW-1:0] want);
        tests_run++;
        if (got !== want) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    function automatic logic [NW-1:0] stepped(input logic [NW-1:0] cur,
        input logic [`DHDS_DEV_W-1:0] dv, input logic dn);
        return dn ? cur - NW'(dv) : cur + NW'(dv);
    endfunction
    task automatic wait_state(input dhds_state_t s);
        for (int n = 0; n < 40 && o_state !== s; n++) tick(1);
        check(NW'(o_state), NW'(s));
    endtask
    task automatic set_ref(input logic ok, input logic tol);
        i_reference_loss = ~ok;
        i_valid_ref_avail = ok;
        i_freq_in_tol = tol;
        i_phase_in_tol = tol;
    endtask
    task automatic conclude();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog: the sequence needs about 1000 cycles
    initial begin
        #200000;
        mismatches++;
        conclude();
    end
    // =============================================
    // sequence
    initial begin
        void'($urandom(32'ha5adc492));
        {i_reset_n, i_ctrl, i_offset_wr, i_fb_num_wr, d} = '0;
        {i_step_update_wr, i_step_update_bit, i_pin_ctrl_en} = '0;
        {i_loop_word, i_holdover_offset_word, i_feedback_numerator} = '0;
        {i_analog_base_numerator, i_step_deviation_word} = '0;
        {i_ramp_step_size, i_ramp_step_period} = '0;
        set_ref(1'b0, 1'b0);
        i_step_trigger_pin_sel = 3'($urandom);
        i_step_direction_pin_sel = i_step_trigger_pin_sel ^ 3'h5;
        tick(16);
        i_reset_n = 1'b1;
        check(NW'(o_state), NW'(DHDS_FREE_RUN));
        check(NW'(o_lock_status), 40'h3);
        i_ctrl.loop_enable = 1'b1;
        i_ctrl.digital_loop_enable = 1'b1;
        i_ctrl.denominator_mode = 1'b1;
        set_ref(1'b1, 1'b1);
        wait_state(DHDS_LOCKED);
        tick(2);
        check(NW'({o_lock_status, o_status_pins}), 40'h0);
        set_ref(1'b0, 1'b0);
        wait_state(DHDS_FREE_RUN);
        // no averaging while the frequency detector is out of tolerance
        i_ctrl.history_enable = 1'b1;
        i_loop_word = {1'b0, 39'($urandom) << 7};
        set_ref(1'b1, 1'b0);
        tick(100);
        check(NW'(o_history_valid), 40'h0);
        set_ref(1'b1, 1'b1);
        wait_state(DHDS_LOCKED);
        // locked but frequency flag raised: averaging must pause
        i_freq_in_tol = 1'b0;
        tick(40);
        check(NW'(o_history_valid), 40'h0);
        i_freq_in_tol = 1'b1;
        // steering while locked: absolute, register and pin steps
        i_ctrl.steering_enable = 1'b1;
        i_feedback_numerator = {8'($urandom), 32'($urandom)};
        exp = i_feedback_numerator;
        i_fb_num_wr = 1'b1;
        tick(1);
        i_fb_num_wr = 1'b0;
        tick(3);
        check(o_fcw, exp);
        i_step_deviation_word = {6'($urandom), 32'($urandom)};
        i_step_update_wr = 1'b1;
        for (int i = 0; i < 8; i++) begin
            i_step_update_bit = (i == 0) ? 1'b0 : 1'($urandom);
            exp = stepped(exp, i_step_deviation_word, i_step_update_bit);
            tick(1);
        end
        i_step_update_wr = 1'b0;
        tick(3);
        check(o_fcw, exp);
        i_pin_ctrl_en = 1'b1;
        for (int i = 0; i < 5; i++) begin
            d = (i == 1) ? 1'b1 : 1'($urandom);
            exp = stepped(exp, i_step_deviation_word, d);
            host.pulse(d);
        end
        check(o_fcw, exp);
        i_pin_ctrl_en = 1'b0;
        host.pulse(1'b0);
        check(o_fcw, exp);
        i_ctrl.steering_enable = 1'b0;
        i_step_update_wr = 1'b1;
        tick(1);
        i_step_update_wr = 1'b0;
        tick(3);
        check(o_fcw, i_feedback_numerator);
        tick(600);
        check(NW'(o_history_valid), 40'h1);
        // holdover keeps the frequency flag although tolerance is lost
        set_ref(1'b0, 1'b0);
        wait_state(DHDS_HOLDOVER);
        tick(3);
        check(NW'(o_lock_status), 40'h1);
        check(NW'(i_loop_word - o_fcw < 40'h10), 40'h1);
        // history off in holdover: base numerator plus signed offset
        i_ctrl.history_enable = 1'b0;
        i_holdover_offset_word = {8'($urandom), 32'($urandom)};
        tick(3);
        exp = i_feedback_numerator + i_holdover_offset_word;
        check(o_fcw, exp);
        set_ref(1'b1, 1'b1);
        wait_state(DHDS_LOCKED);
        tick(2);
        check(NW'(o_lock_status), 40'h0);
        // analog numerator steering: absolute, then paced
        i_ctrl.digital_loop_enable = 1'b0;
        i_ctrl.history_enable = 1'b0;
        i_analog_base_numerator = {8'($urandom), 32'($urandom)};
        i_holdover_offset_word = {8'hff, 32'($urandom)};
        i_offset_wr = 1'b1;
        tick(1);
        i_offset_wr = 1'b0;
        tick(3);
        exp = i_analog_base_numerator + i_holdover_offset_word;
        check(o_effective_analog_numerator, exp);
        i_ctrl.history_enable = 1'b1;
        i_ramp_step_size = NW'($urandom_range(255, 16));
        i_ramp_step_period = 16'($urandom_range(3, 1));
        o2 = i_holdover_offset_word + 40 * i_ramp_step_size + 40'h7;
        for (int k = 0; k < 2; k++) begin
            i_holdover_offset_word = o2;
            i_offset_wr = 1'b1;
            tick(1);
            i_offset_wr = 1'b0;
            tick(5);
            exp = i_analog_base_numerator + o2;
            check(NW'(o_ramp_done), 40'h0);
            check(NW'(o_effective_analog_numerator == exp), 40'h0);
            o2 = o2 - 30 * i_ramp_step_size + 40'h3;
        end
        for (int n = 0; n < 400 && o_ramp_done !== 1'b1; n++) tick(1);
        check(o_effective_analog_numerator, exp);
        check(NW'(o_ramp_done), 40'h1);
        i_ctrl.digital_loop_enable = 1'b1;
        wait_state(DHDS_LOCKED);
        tick(3);
        check(o_effective_analog_numerator, i_analog_base_numerator);
        conclude();
    end
endmodule
